// ===== shared/pcfg_params.svh
// register offsets, reset values and field sizes for the port 2/3 pin control block
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
`define PCFG_ADDR_P2_DATA    8'ha0
`define PCFG_ADDR_P2_DRIVE   8'ha6
`define PCFG_ADDR_P3_DRIVE   8'ha7
`define PCFG_ADDR_P3_DATA    8'hb0
`define PCFG_ADDR_P2_BYPASS  8'hd6
`define PCFG_ADDR_P2_ANALOG  8'hf3
`define PCFG_ADDR_P3_ANALOG  8'hf4
`define PCFG_RST_DATA        8'hff
`define PCFG_RST_ANALOG      8'hff
`define PCFG_RST_DRIVE       8'h00
`define PCFG_RST_BYPASS      8'h00
`define PCFG_BIT_IDX_W       3
`endif

// ===== shared/pcfg_pkg.sv
// types for the port 2/3 pin control block
package pcfg_pkg;
   typedef logic [7:0] pcfg_byte_t;
   typedef enum logic [2:0] {
      PCFG_SEL_NONE    = 3'b000,
      PCFG_SEL_P2DATA  = 3'b001,
      PCFG_SEL_P3DATA  = 3'b010,
      PCFG_SEL_P2DRV   = 3'b011,
      PCFG_SEL_P3DRV   = 3'b100,
      PCFG_SEL_P2BYP   = 3'b101,
      PCFG_SEL_P2ANA   = 3'b110,
      PCFG_SEL_P3ANA   = 3'b111
   } pcfg_sel_e;
endpackage : pcfg_pkg

// ===== core/pcfg_port23.sv
// port 2 and port 3 pin control: data latches, pin readback, mode and skip registers
// Functional notes
// - data register write sets output latch low for 0, high for 1; reset all ones.
// - reading a data register returns the live levels of digital pins, not the latch; analog pins read 0.
// - data registers reachable from any page, by byte or single bit.
// - input mode bit 0 selects analog, 1 digital; resets to all ones.
// - analog pin has pull-up, output driver and input receiver all off.
// - output mode bit 0 selects open-drain, 1 push-pull; resets to zero.
// - output mode setting ignored while the pin is analog.
// - port 2 skip bit 1 makes crossbar pass the pin over; resets zero.
`timescale 1ns/1ps
`include "pcfg_params.svh"
module pcfg_port23 #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [7:0]       regAddr,
   input  wire logic             regWrite,
   input  wire logic             regRead,
   input  wire logic [7:0]       regWdata,
   input  wire logic             bitWrite,
   input  wire logic [2:0]       bitIndex,
   input  wire logic             bitValue,
   output logic      [7:0]       regRdata,
   output logic                  regHit,
   input  wire logic [WIDTH-1:0] port2PinIn,
   output logic      [WIDTH-1:0] port2PinOut,
   output logic      [WIDTH-1:0] port2PinOe,
   output logic      [WIDTH-1:0] port2PullupEn,
   output logic      [WIDTH-1:0] port2InputEn,
   input  wire logic [WIDTH-1:0] port3PinIn,
   output logic      [WIDTH-1:0] port3PinOut,
   output logic      [WIDTH-1:0] port3PinOe,
   output logic      [WIDTH-1:0] port3PullupEn,
   output logic      [WIDTH-1:0] port3InputEn,
   output logic      [WIDTH-1:0] port2CrossbarSkip
);
   if (WIDTH != 8) begin : g_width_check
      $error("pcfg_port23: WIDTH must be 8");
   end
   if (`PCFG_BIT_IDX_W != $clog2(WIDTH)) begin : g_index_check
      $error("pcfg_port23: bit index width does not cover WIDTH");
   end

   function automatic pcfg_pkg::pcfg_sel_e decodeAddr(input logic [7:0] a);
      unique case (a)
         `PCFG_ADDR_P2_DATA:   decodeAddr = pcfg_pkg::PCFG_SEL_P2DATA;
         `PCFG_ADDR_P3_DATA:   decodeAddr = pcfg_pkg::PCFG_SEL_P3DATA;
         `PCFG_ADDR_P2_DRIVE:  decodeAddr = pcfg_pkg::PCFG_SEL_P2DRV;
         `PCFG_ADDR_P3_DRIVE:  decodeAddr = pcfg_pkg::PCFG_SEL_P3DRV;
         `PCFG_ADDR_P2_BYPASS: decodeAddr = pcfg_pkg::PCFG_SEL_P2BYP;
         `PCFG_ADDR_P2_ANALOG: decodeAddr = pcfg_pkg::PCFG_SEL_P2ANA;
         `PCFG_ADDR_P3_ANALOG: decodeAddr = pcfg_pkg::PCFG_SEL_P3ANA;
         default:              decodeAddr = pcfg_pkg::PCFG_SEL_NONE;
      endcase
   endfunction : decodeAddr

   // single-bit update of a byte; bit access reads latch, modifies, writes latch
   function automatic pcfg_pkg::pcfg_byte_t bitMerge(input pcfg_pkg::pcfg_byte_t base,
                                                      input logic [2:0] idx, input logic v);
      pcfg_pkg::pcfg_byte_t t;
      t = base;
      t[idx] = v;
      bitMerge = t;
   endfunction : bitMerge

   pcfg_pkg::pcfg_sel_e  sel;
   pcfg_pkg::pcfg_byte_t p2Data_r;
   pcfg_pkg::pcfg_byte_t p3Data_r;
   pcfg_pkg::pcfg_byte_t p2Drv_r;
   pcfg_pkg::pcfg_byte_t p3Drv_r;
   pcfg_pkg::pcfg_byte_t p2Byp_r;
   pcfg_pkg::pcfg_byte_t p2Ana_r;
   pcfg_pkg::pcfg_byte_t p3Ana_r;
   // write strobes; a byte write takes precedence over a bit write
   logic                 wrP2Data;
   logic                 wrP3Data;
   logic                 bitP2Data;
   logic                 bitP3Data;
   logic                 wrP2Ana;
   logic                 wrP3Ana;
   logic                 wrP2Drv;
   logic                 wrP3Drv;
   logic                 wrP2Byp;

   assign sel       = decodeAddr(regAddr);
   assign regHit    = (sel != pcfg_pkg::PCFG_SEL_NONE);
   assign wrP2Data  = regWrite & (sel == pcfg_pkg::PCFG_SEL_P2DATA);
   assign wrP3Data  = regWrite & (sel == pcfg_pkg::PCFG_SEL_P3DATA);
   assign bitP2Data = bitWrite & ~regWrite & (sel == pcfg_pkg::PCFG_SEL_P2DATA);
   assign bitP3Data = bitWrite & ~regWrite & (sel == pcfg_pkg::PCFG_SEL_P3DATA);
   assign wrP2Ana   = regWrite & (sel == pcfg_pkg::PCFG_SEL_P2ANA);
   assign wrP3Ana   = regWrite & (sel == pcfg_pkg::PCFG_SEL_P3ANA);
   assign wrP2Drv   = regWrite & (sel == pcfg_pkg::PCFG_SEL_P2DRV);
   assign wrP3Drv   = regWrite & (sel == pcfg_pkg::PCFG_SEL_P3DRV);
   assign wrP2Byp   = regWrite & (sel == pcfg_pkg::PCFG_SEL_P2BYP);

   // data latches are written by byte or by bit, with no page select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p2Data_r <= `PCFG_RST_DATA;
      end else if (wrP2Data) begin
         p2Data_r <= regWdata;
      end else if (bitP2Data) begin
         p2Data_r <= bitMerge(p2Data_r, bitIndex, bitValue);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p3Data_r <= `PCFG_RST_DATA;
      end else if (wrP3Data) begin
         p3Data_r <= regWdata;
      end else if (bitP3Data) begin
         p3Data_r <= bitMerge(p3Data_r, bitIndex, bitValue);
      end
   end

   // mode and skip registers, byte write only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p2Ana_r <= `PCFG_RST_ANALOG;
      end else if (wrP2Ana) begin
         p2Ana_r <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p3Ana_r <= `PCFG_RST_ANALOG;
      end else if (wrP3Ana) begin
         p3Ana_r <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p2Drv_r <= `PCFG_RST_DRIVE;
      end else if (wrP2Drv) begin
         p2Drv_r <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p3Drv_r <= `PCFG_RST_DRIVE;
      end else if (wrP3Drv) begin
         p3Drv_r <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p2Byp_r <= `PCFG_RST_BYPASS;
      end else if (wrP2Byp) begin
         p2Byp_r <= regWdata;
      end
   end

   // read data registered; data registers return digital pin levels, analog pins read 0
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         unique case (sel)
            pcfg_pkg::PCFG_SEL_P2DATA: regRdata <= port2PinIn & p2Ana_r;
            pcfg_pkg::PCFG_SEL_P3DATA: regRdata <= port3PinIn & p3Ana_r;
            pcfg_pkg::PCFG_SEL_P2DRV:  regRdata <= p2Drv_r;
            pcfg_pkg::PCFG_SEL_P3DRV:  regRdata <= p3Drv_r;
            pcfg_pkg::PCFG_SEL_P2BYP:  regRdata <= p2Byp_r;
            pcfg_pkg::PCFG_SEL_P2ANA:  regRdata <= p2Ana_r;
            pcfg_pkg::PCFG_SEL_P3ANA:  regRdata <= p3Ana_r;
            pcfg_pkg::PCFG_SEL_NONE:   regRdata <= 8'h00;
         endcase
      end
   end

   // pin cells, one per pin and port
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_cell
         pcfg_pin_cell u_p2cell (
            .latch    (p2Data_r[i]),
            .digital  (p2Ana_r[i]),
            .pushPull (p2Drv_r[i]),
            .pinOut   (port2PinOut[i]),
            .pinOe    (port2PinOe[i]),
            .pullupEn (port2PullupEn[i]),
            .inputEn  (port2InputEn[i])
         );
         pcfg_pin_cell u_p3cell (
            .latch    (p3Data_r[i]),
            .digital  (p3Ana_r[i]),
            .pushPull (p3Drv_r[i]),
            .pinOut   (port3PinOut[i]),
            .pinOe    (port3PinOe[i]),
            .pullupEn (port3PullupEn[i]),
            .inputEn  (port3InputEn[i])
         );
      end
   endgenerate

   assign port2CrossbarSkip = p2Byp_r;

endmodule : pcfg_port23

// one pad cell: mode bits to driver, pull-up and receiver enables
module pcfg_pin_cell (
   input  wire logic latch,
   input  wire logic digital,
   input  wire logic pushPull,
   output logic      pinOut,
   output logic      pinOe,
   output logic      pullupEn,
   output logic      inputEn
);
   // push-pull drives both levels; open-drain drives only a low
   assign pinOut   = latch;
   assign pinOe    = digital & (pushPull | ~latch);
   // weak pull-up only on a released open-drain digital pin
   assign pullupEn = digital & ~pushPull & latch;
   assign inputEn  = digital;
endmodule : pcfg_pin_cell

// ===== dv/pcfg_pin_model.sv
// pad model: resolves pin level from device drive, external driver and pull-up
`timescale 1ns/1ps
module pcfg_pin_model (
   input  wire logic [7:0] out, oe, pu, extV, extE,
   output logic      [7:0] lvl
);
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (oe[i]) lvl[i] = out[i];
         else if (extE[i]) lvl[i] = extV[i];
         else if (pu[i]) lvl[i] = 1'b1;
         else lvl[i] = ~out[i];
      end
   end
endmodule : pcfg_pin_model

// ===== dv/pcfg_port23_assertions.sv
// checker: register-to-pin relations of the port 2/3 pin control block
`timescale 1ns/1ps
module pcfg_port23_chk #(
   parameter int WIDTH = 8
) (
   input wire logic             clk,
   input wire logic             reset_n,
   input wire logic             regWrite,
   input wire logic             regRead,
   input wire logic             bitWrite,
   input wire logic             bitValue,
   input wire logic             regHit,
   input wire logic [2:0]       bitIndex,
   input wire logic [7:0]       regAddr,
   input wire logic [7:0]       regWdata,
   input wire logic [7:0]       regRdata,
   input wire logic [WIDTH-1:0] port2PinIn,
   input wire logic [WIDTH-1:0] port2PinOut,
   input wire logic [WIDTH-1:0] port2PinOe,
   input wire logic [WIDTH-1:0] port2PullupEn,
   input wire logic [WIDTH-1:0] port2InputEn,
   input wire logic [WIDTH-1:0] port3PinOut,
   input wire logic [WIDTH-1:0] port3PinOe,
   input wire logic [WIDTH-1:0] port3PullupEn,
   input wire logic [WIDTH-1:0] port3InputEn,
   input wire logic [WIDTH-1:0] port2CrossbarSkip
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_wr(a); regWrite && regAddr == a; endsequence
   property p_ana; ((port2PinOe | port2PullupEn) & ~port2InputEn) == '0; endproperty
   a_ana: assert property (p_ana) else $error("analog pin driven");
   property p_drv; (port2PinOe ^ port2PullupEn) == port2InputEn; endproperty
   a_drv: assert property (p_drv) else $error("drive mode wrong");
   property p_ana3; ((port3PinOe | port3PullupEn) & ~port3InputEn) == '0; endproperty
   a_ana3: assert property (p_ana3) else $error("port3 analog pin driven");
   property p_drv3; (port3PinOe ^ port3PullupEn) == port3InputEn; endproperty
   a_drv3: assert property (p_drv3) else $error("port3 drive mode wrong");
   property p_wr2; s_wr(8'ha0) |=> port2PinOut == $past(regWdata); endproperty
   a_wr2: assert property (p_wr2) else $error("port2 latch");
   property p_wr3; s_wr(8'hb0) |=> port3PinOut == $past(regWdata); endproperty
   a_wr3: assert property (p_wr3) else $error("port3 latch");
   property p_bit; bitWrite && !regWrite && regAddr == 8'hb0 |=> port3PinOut[$past(bitIndex)] == $past(bitValue);
   endproperty
   a_bit: assert property (p_bit) else $error("bit write");
   property p_rd; regRead && regAddr == 8'ha0 |=> regRdata == $past(port2PinIn & port2InputEn); endproperty
   a_rd: assert property (p_rd) else $error("pin read");
   property p_skp; s_wr(8'hd6) |=> port2CrossbarSkip == $past(regWdata); endproperty
   a_skp: assert property (p_skp) else $error("skip");
   property p_miss; regRead && !regHit |=> regRdata == 8'h00; endproperty
   a_miss: assert property (p_miss) else $error("unmapped read");
   property p_hold; !regRead |=> $stable(regRdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule : pcfg_port23_chk
bind pcfg_port23 pcfg_port23_chk #(.WIDTH(WIDTH)) u_chk (
   .clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead), .bitWrite(bitWrite),
   .bitValue(bitValue), .regHit(regHit), .bitIndex(bitIndex), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .port2PinIn(port2PinIn), .port2PinOut(port2PinOut), .port2PinOe(port2PinOe),
   .port2PullupEn(port2PullupEn), .port2InputEn(port2InputEn), .port3PinOut(port3PinOut),
   .port3PinOe(port3PinOe), .port3PullupEn(port3PullupEn), .port3InputEn(port3InputEn),
   .port2CrossbarSkip(port2CrossbarSkip)
);

// ===== dv/tb.sv
// testbench: register access sequences against the pad model
`timescale 1ns/1ps
module tb;
   logic       clk, reset_n, regWrite, regRead, bitWrite, bitValue, regHit;
   logic [2:0] bitIndex;
   logic [7:0] regAddr, regWdata, regRdata, port2PinIn, port2PinOut, port2PinOe, port2PullupEn, port2InputEn;
   logic [7:0] port3PinIn, port3PinOut, port3PinOe, port3PullupEn, port3InputEn, port2CrossbarSkip, ext2, ext2En;
   logic [7:0] ra[5] = '{8'ha6, 8'ha7, 8'hd6, 8'hf3, 8'hf4};
   logic [7:0] rr[5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
   int         fails, cmp_count;
   pcfg_port23 dut (.*);
   pcfg_pin_model m2 (.out(port2PinOut), .oe(port2PinOe), .pu(port2PullupEn), .extV(ext2), .extE(ext2En), .lvl(port2PinIn));
   pcfg_pin_model m3 (.out(port3PinOut), .oe(port3PinOe), .pu(port3PullupEn), .extV(8'h00), .extE(8'h00), .lvl(port3PinIn));
   task automatic chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d, input logic b = 1'b0, input logic [2:0] i = 3'd0);
      regAddr = a;
      regWdata = d;
      bitIndex = i;
      bitValue = d[0];
      {regWrite, bitWrite} = {!b, b};
      @(negedge clk) {regWrite, bitWrite} = 2'b00;
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, exp);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk) regRead = 1'b0;
      @(negedge clk) chk(regRdata, exp);
   endtask : rd
   task automatic results;
      $display("fails=%0d compares=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // whole sequence is under 200 cycles
   initial begin
      #20000 fails++;
      results();
   end
   initial begin
      {reset_n, regWrite, regRead, bitWrite, bitValue, bitIndex, regAddr, regWdata, fails, cmp_count} = '0;
      {ext2, ext2En} = 16'h3cff;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      chk(port2PinOut, 8'hff);
      chk(port2CrossbarSkip, 8'h00);
      foreach (ra[i]) rd(ra[i], rr[i]);
      rd(8'ha0, 8'h3c);
      wr(8'hb0, 8'h00, 1'b1, 3'd3);
      wr(8'ha6, 8'h01, 1'b1, 3'd0);
      rd(8'hb0, 8'hf7);
      rd(8'ha6, 8'h00);
      ext2En = 8'h00;
      wr(8'ha0, 8'h55);
      chk(port2PinOe, 8'haa);
      wr(8'ha6, 8'hff);
      chk(port2PullupEn, 8'h00);
      wr(8'hf3, 8'h0f);
      chk(port2InputEn, 8'h0f);
      chk(port2PinOe, 8'h0f);
      wr(8'ha6, 8'h00);
      chk(port2PinOe, 8'h0a);
      rd(8'ha0, 8'h05);
      wr(8'hd6, 8'hf0);
      chk(port2CrossbarSkip, 8'hf0);
      wr(8'hb0, 8'h5a);
      chk(port3PinOut, 8'h5a);
      wr(8'hf4, 8'hf0);
      wr(8'ha7, 8'hff);
      chk(port3PinOe, 8'hf0);
      chk(port3PullupEn, 8'h00);
      chk(port3InputEn, 8'hf0);
      rd(8'hb0, 8'h50);
      reset_n = 1'b0;
      @(negedge clk) reset_n = 1'b1;
      chk(port3PinOut, 8'hff);
      chk(port2PullupEn, 8'hff);
      chk(port3InputEn, 8'hff);
      chk(port3PinOe, 8'h00);
      chk(port2CrossbarSkip, 8'h00);
      rd(8'h00, 8'h00);
      chk({7'h0, regHit}, 8'h00);
      results();
   end
endmodule : tb
